// *** obr_pkg.sv ***
//------------------------------------------------------------------------
// What this block does
//------------------------------------------------------------------------
// What this block does
// - A rising edge on each capture clock stores its source bus.
// - Capture happens on every edge whatever enable, direction or select.
// - A-to-B capture still stores A data while B is driven.
// - B-to-A capture still stores B data while A is driven.
// - Enable high isolates both sides; registers capture or else hold.
// - The output enable is active low; only then is a bus driven.
// - Direction low drives side A; direction high drives side B.
// - Direction low, B-to-A select low: side A gets live B data.
// - Direction low, B-to-A select high: side A gets the B-to-A register.
// - Direction high, A-to-B select low: side B gets live A data.
// - Direction high, A-to-B select high: side B gets the A-to-B register.
// - Never drive both buses; outside logic leaves the driven side alone.
`default_nettype none

package obr_pkg;

  //----------------------------------------------------------------------
  // Sizes
  //----------------------------------------------------------------------
  localparam int OBR_DATA_W = 8;
  localparam int OBR_ADDR_W = 4;
  localparam int OBR_SYNC_STAGES = 2;

  //----------------------------------------------------------------------
  // Register map, byte addresses
  //----------------------------------------------------------------------
  localparam logic [3:0] OBR_CTRL_OFS = 4'h0;
  localparam logic [3:0] OBR_STATUS_OFS = 4'h4;
  localparam logic [3:0] OBR_A2B_OFS = 4'h8;
  localparam logic [3:0] OBR_B2A_OFS = 4'hC;

  //----------------------------------------------------------------------
  // Field positions and reset values
  //----------------------------------------------------------------------
  localparam int OBR_CTRL_ISOLATE_BIT = 0;
  localparam int OBR_STAT_A_DRIVEN_BIT = 0;
  localparam int OBR_STAT_B_DRIVEN_BIT = 1;
  localparam int OBR_STAT_PINS_LSB = 2;
  localparam logic [OBR_DATA_W-1:0] OBR_STORE_RST = 8'h00;
  localparam logic [31:0] OBR_RDATA_RST = 32'h00000000;

  // Pins that arrive from outside the clock domain, sampled together.
  typedef struct packed {
    logic cp_ab;
    logic cp_ba;
    logic oe_n;
    logic dir;
    logic sel_ab;
    logic sel_ba;
    logic [OBR_DATA_W-1:0] a;
    logic [OBR_DATA_W-1:0] b;
  } obr_pins_t;

  // Sampled pins after reset: enable off and both capture clocks high, so a
  // pin that idles high cannot fake a capture edge on release. Field order
  // is cp_ab, cp_ba, oe_n, dir, sel_ab, sel_ba, a, b.
  localparam obr_pins_t OBR_PINS_RST = {1'h1, 1'h1, 1'h1, 3'h0, 8'h00, 8'h00};

  // One driven side of the transceiver.
  typedef struct packed {
    logic oe;
    logic [OBR_DATA_W-1:0] data;
  } obr_drive_t;

endpackage

`default_nettype wire

// *** obr_core.sv ***
`timescale 1ns/10ps
`default_nettype none

module obr_core
  import obr_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Control pins
  input wire logic a_to_b_capture_clock,
  input wire logic b_to_a_capture_clock,
  input wire logic output_enable_n,
  input wire logic direction,
  input wire logic a_to_b_stored_select,
  input wire logic b_to_a_stored_select,
  // Side A bus pins
  input wire logic [OBR_DATA_W-1:0] side_a_bus_in,
  output logic [OBR_DATA_W-1:0] side_a_bus_out,
  output logic side_a_bus_oe,
  // Side B bus pins
  input wire logic [OBR_DATA_W-1:0] side_b_bus_in,
  output logic [OBR_DATA_W-1:0] side_b_bus_out,
  output logic side_b_bus_oe,
  // Avalon-MM slave
  input wire logic [OBR_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);

  //----------------------------------------------------------------------
  // Input synchronisers
  //----------------------------------------------------------------------
  obr_pins_t pins_raw;
  obr_pins_t pins_ff1;
  obr_pins_t pins_s;
  logic cp_ab_d;
  logic cp_ba_d;
  logic rise_ab;
  logic rise_ba;

  assign pins_raw = '{cp_ab: a_to_b_capture_clock,
                      cp_ba: b_to_a_capture_clock,
                      oe_n: output_enable_n,
                      dir: direction,
                      sel_ab: a_to_b_stored_select,
                      sel_ba: b_to_a_stored_select,
                      a: side_a_bus_in,
                      b: side_b_bus_in};

  // Clock pins and data share one chain, so a sampled edge lines up with
  // the data that stood beside it. The first stage feeds the second only.
  // Reset loads idle levels, so release neither drives nor captures.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pins_ff1 <= OBR_PINS_RST;
      pins_s <= OBR_PINS_RST;
    end else begin
      pins_ff1 <= pins_raw;
      pins_s <= pins_ff1;
    end
  end

  // A third stage on the capture clocks gives the edge detectors a history.
  // It resets to the same level as the sampled pins to avoid a false edge.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cp_ab_d <= OBR_PINS_RST.cp_ab;
      cp_ba_d <= OBR_PINS_RST.cp_ba;
    end else begin
      cp_ab_d <= pins_s.cp_ab;
      cp_ba_d <= pins_s.cp_ba;
    end
  end

  assign rise_ab = pins_s.cp_ab & ~cp_ab_d;
  assign rise_ba = pins_s.cp_ba & ~cp_ba_d;

  //----------------------------------------------------------------------
  // Storage registers
  //----------------------------------------------------------------------
  logic [OBR_DATA_W-1:0] store_ab;
  logic [OBR_DATA_W-1:0] store_ba;

  // Capture is never gated by enable, direction or select, so the side
  // being driven can still be snapshotted from the other one.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      store_ab <= OBR_STORE_RST;
    end else if (rise_ab) begin
      store_ab <= pins_s.a;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      store_ba <= OBR_STORE_RST;
    end else if (rise_ba) begin
      store_ba <= pins_s.b;
    end
  end

  //----------------------------------------------------------------------
  // Output steering
  //----------------------------------------------------------------------
  logic force_isolate;
  obr_drive_t next_drive_a;
  obr_drive_t next_drive_b;

  // Live data goes out one clock after it was sampled; the pin path is
  // registered, which costs a cycle but keeps glitches off the bus.
  always_comb begin
    next_drive_a.oe = ~pins_s.oe_n & ~pins_s.dir & ~force_isolate;
    next_drive_b.oe = ~pins_s.oe_n & pins_s.dir & ~force_isolate;
    next_drive_a.data = pins_s.sel_ba ? store_ba : pins_s.b;
    next_drive_b.data = pins_s.sel_ab ? store_ab : pins_s.a;
  end

  // Both enables decode from the same direction bit, so they can never be
  // high together.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      side_a_bus_oe <= 1'b0;
      side_b_bus_oe <= 1'b0;
      side_a_bus_out <= OBR_STORE_RST;
      side_b_bus_out <= OBR_STORE_RST;
    end else begin
      side_a_bus_oe <= next_drive_a.oe;
      side_b_bus_oe <= next_drive_b.oe;
      side_a_bus_out <= next_drive_a.data;
      side_b_bus_out <= next_drive_b.data;
    end
  end

  //----------------------------------------------------------------------
  // Avalon-MM slave
  //----------------------------------------------------------------------
  logic bus_req;
  logic bus_take;
  logic [31:0] next_rdata;

  assign bus_req = avs_read | avs_write;
  // A request completes at the edge where waitrequest is seen low.
  assign bus_take = bus_req & ~avs_waitrequest;

  // Every access is answered with one wait cycle.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= ~(bus_req & avs_waitrequest);
    end
  end

  // Software isolation lets firmware park the bus regardless of the pins.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      force_isolate <= 1'b0;
    end else if (bus_take && avs_write && avs_address == OBR_CTRL_OFS) begin
      force_isolate <= avs_writedata[OBR_CTRL_ISOLATE_BIT];
    end
  end

  // Unmapped addresses read as zero and swallow writes.
  always_comb begin
    next_rdata = '0;
    case (avs_address)
      OBR_CTRL_OFS: begin
        next_rdata[OBR_CTRL_ISOLATE_BIT] = force_isolate;
      end
      OBR_STATUS_OFS: begin
        next_rdata[OBR_STAT_A_DRIVEN_BIT] = side_a_bus_oe;
        next_rdata[OBR_STAT_B_DRIVEN_BIT] = side_b_bus_oe;
        next_rdata[OBR_STAT_PINS_LSB +: 6] = {pins_s.cp_ab, pins_s.cp_ba,
          pins_s.oe_n, pins_s.dir, pins_s.sel_ab, pins_s.sel_ba};
      end
      OBR_A2B_OFS: begin
        next_rdata[OBR_DATA_W-1:0] = store_ab;
      end
      OBR_B2A_OFS: begin
        next_rdata[OBR_DATA_W-1:0] = store_ba;
      end
      default: begin
        next_rdata = '0;
      end
    endcase
  end

  // Read data is loaded in the wait cycle and stands at the completing edge.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      avs_readdata <= OBR_RDATA_RST;
    end else if (avs_read && avs_waitrequest) begin
      avs_readdata <= next_rdata;
    end
  end

  //----------------------------------------------------------------------
  // Assertions
  //----------------------------------------------------------------------
  sequence s_rise_ab;
    !cp_ab_d ##0 pins_s.cp_ab;
  endsequence

  sequence s_rise_ba;
    !cp_ba_d ##0 pins_s.cp_ba;
  endsequence

  sequence s_drive_a_live;
    !pins_s.oe_n && !pins_s.dir && !force_isolate && !pins_s.sel_ba;
  endsequence

  property p_store_ab;
    @(posedge clk_sys) disable iff (sys_rst)
    s_rise_ab |=> store_ab == $past(pins_s.a);
  endproperty
  a_store_ab: assert property (p_store_ab)
    else $error("A-to-B register missed its capture.");

  property p_store_ba;
    @(posedge clk_sys) disable iff (sys_rst)
    s_rise_ba |=> store_ba == $past(pins_s.b);
  endproperty
  a_store_ba: assert property (p_store_ba)
    else $error("B-to-A register missed its capture.");

  property p_hold;
    @(posedge clk_sys) disable iff (sys_rst)
    (!rise_ab && !rise_ba) |=> $stable(store_ab) && $stable(store_ba);
  endproperty
  a_hold: assert property (p_hold)
    else $error("A storage register changed without a capture edge.");

  property p_isolate;
    @(posedge clk_sys) disable iff (sys_rst)
    pins_s.oe_n |=> !side_a_bus_oe && !side_b_bus_oe;
  endproperty
  a_isolate: assert property (p_isolate)
    else $error("A bus is driven while output enable is high.");

  property p_one_side;
    @(posedge clk_sys) disable iff (sys_rst)
    !(side_a_bus_oe && side_b_bus_oe);
  endproperty
  a_one_side: assert property (p_one_side)
    else $error("Both buses are driven at once.");

  property p_dir_b;
    @(posedge clk_sys) disable iff (sys_rst)
    (!pins_s.oe_n && pins_s.dir && !force_isolate)
      |=> side_b_bus_oe && !side_a_bus_oe;
  endproperty
  a_dir_b: assert property (p_dir_b)
    else $error("Direction high did not drive side B alone.");

  property p_live_a;
    @(posedge clk_sys) disable iff (sys_rst)
    s_drive_a_live |=> side_a_bus_oe && side_a_bus_out == $past(pins_s.b);
  endproperty
  a_live_a: assert property (p_live_a)
    else $error("Side A does not carry live B data.");

  property p_stored_a;
    @(posedge clk_sys) disable iff (sys_rst)
    (!pins_s.oe_n && !pins_s.dir && !force_isolate && pins_s.sel_ba)
      |=> side_a_bus_out == $past(store_ba);
  endproperty
  a_stored_a: assert property (p_stored_a)
    else $error("Side A does not carry the B-to-A register.");

  property p_live_b;
    @(posedge clk_sys) disable iff (sys_rst)
    !pins_s.sel_ab |=> side_b_bus_out == $past(pins_s.a);
  endproperty
  a_live_b: assert property (p_live_b)
    else $error("Side B does not carry live A data.");

  property p_stored_b;
    @(posedge clk_sys) disable iff (sys_rst)
    pins_s.sel_ab |=> side_b_bus_out == $past(store_ab);
  endproperty
  a_stored_b: assert property (p_stored_b)
    else $error("Side B does not carry the A-to-B register.");

  property p_reset_state;
    @(posedge clk_sys)
    sys_rst |=> !side_a_bus_oe && !side_b_bus_oe
      && store_ab == OBR_STORE_RST && store_ba == OBR_STORE_RST;
  endproperty
  a_reset_state: assert property (p_reset_state)
    else $error("Reset did not float the buses and clear storage.");

  property p_bus_answer;
    @(posedge clk_sys) disable iff (sys_rst)
    (bus_req && avs_waitrequest) |=> !avs_waitrequest ##1 avs_waitrequest;
  endproperty
  a_bus_answer: assert property (p_bus_answer)
    else $error("Bus access was not answered after one wait cycle.");

  property p_dir_a;
    @(posedge clk_sys) disable iff (sys_rst)
    (!pins_s.oe_n && !pins_s.dir && !force_isolate)
      |=> side_a_bus_oe && !side_b_bus_oe;
  endproperty
  a_dir_a: assert property (p_dir_a)
    else $error("Direction low did not drive side A alone.");

  sequence s_both_off;
    !side_a_bus_oe && !side_b_bus_oe;
  endsequence

  // Stale pin samples must not switch a driver on just after reset.
  property p_float_after_reset;
    @(posedge clk_sys)
    $fell(sys_rst) |-> s_both_off ##1 s_both_off;
  endproperty
  a_float_after_reset: assert property (p_float_after_reset)
    else $error("A bus was driven right after reset.");

  // Both capture clocks may rise together while the buses are isolated.
  property p_store_both;
    @(posedge clk_sys) disable iff (sys_rst)
    (pins_s.oe_n && rise_ab && rise_ba)
      |=> store_ab == $past(pins_s.a) && store_ba == $past(pins_s.b);
  endproperty
  a_store_both: assert property (p_store_both)
    else $error("Simultaneous captures did not store both sides.");

  // Read data must stand between reads so a slow master still sees it.
  property p_rdata_hold;
    @(posedge clk_sys) disable iff (sys_rst)
    !avs_read |=> $stable(avs_readdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("Read data changed without a read.");

endmodule

`default_nettype wire

// *** obr_far.sv ***
`timescale 1ns/10ps
`default_nettype none

// Outside logic on both buses of the transceiver.
module obr_far
  import obr_pkg::*;
(
  // Levels the outside logic wants on each bus
  input wire logic [OBR_DATA_W-1:0] a_val,
  input wire logic [OBR_DATA_W-1:0] b_val,
  // Block drive of each side
  input wire logic [OBR_DATA_W-1:0] a_out,
  input wire logic a_oe,
  input wire logic [OBR_DATA_W-1:0] b_out,
  input wire logic b_oe,
  // Resolved wire levels
  output logic [OBR_DATA_W-1:0] a_wire,
  output logic [OBR_DATA_W-1:0] b_wire
);
  // The far side lets go of a driven bus, which avoids any contention.
  assign a_wire = a_oe ? a_out : a_val;
  assign b_wire = b_oe ? b_out : b_val;
endmodule

`default_nettype wire

// *** testbench.sv ***
`timescale 1ns/10ps
`default_nettype none

module testbench;
  import obr_pkg::*;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic cp_ab = 1'b0;
  logic cp_ba = 1'b0;
  logic oe_n = 1'b1;
  logic dir = 1'b0;
  logic sel_ab = 1'b0;
  logic sel_ba = 1'b0;
  logic [7:0] a_val = 8'h00;
  logic [7:0] b_val = 8'h00;
  logic [7:0] a_in, b_in, a_out, b_out;
  logic a_oe, b_oe;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, rd;
  logic avs_waitrequest;
  int fail_count = 0;
  int n_checks = 0;

  // The clock toggles every half period of 5 ns.
  always #5 clk_sys = ~clk_sys;

  obr_core dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .a_to_b_capture_clock(cp_ab), .b_to_a_capture_clock(cp_ba),
    .output_enable_n(oe_n), .direction(dir),
    .a_to_b_stored_select(sel_ab), .b_to_a_stored_select(sel_ba),
    .side_a_bus_in(a_in), .side_a_bus_out(a_out), .side_a_bus_oe(a_oe),
    .side_b_bus_in(b_in), .side_b_bus_out(b_out), .side_b_bus_oe(b_oe),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

  obr_far far (.a_val(a_val), .b_val(b_val), .a_out(a_out), .a_oe(a_oe),
    .b_out(b_out), .b_oe(b_oe), .a_wire(a_in), .b_wire(b_in));

  //----------------------------------------------------------------------
  // Shared tasks
  //----------------------------------------------------------------------
  // Compares one value and counts it.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // One Avalon access, held until waitrequest is seen low.
  task automatic bus(input logic w, input logic [3:0] ad,
                     input logic [31:0] wd);
    avs_address <= ad;
    avs_writedata <= wd;
    avs_read <= ~w;
    avs_write <= w;
    do begin
      @(posedge clk_sys);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk_sys);
  endtask

  // Pins need three edges to reach the outputs; a turnaround needs six,
  // since the old drive must drop before the far value is sampled.
  task automatic settle();
    repeat (8) @(posedge clk_sys);
  endtask

  // Capture pulses last three cycles each way, above the sync minimum.
  task automatic pulse(input logic ab, input logic ba);
    cp_ab <= ab;
    cp_ba <= ba;
    repeat (3) @(posedge clk_sys);
    cp_ab <= 1'b0;
    cp_ba <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask

  //----------------------------------------------------------------------
  // Scenarios
  //----------------------------------------------------------------------
  task automatic t_reset();
    chk(a_oe, 0);
    chk(b_oe, 0);
    bus(0, OBR_A2B_OFS, 0); chk(rd, 0);
    bus(0, OBR_B2A_OFS, 0); chk(rd, 0);
    bus(0, 4'h2, 0); chk(rd, 0);
    $display("reset test done");
  endtask

  task automatic t_ab();
    oe_n <= 0; dir <= 1; sel_ab <= 0; a_val <= 8'h5A; b_val <= 8'h00;
    settle();
    chk(b_oe, 1);
    chk(a_oe, 0);
    chk(b_out, 8'h5A);
    // Status: side B driven (bit 1) and the sampled direction pin (bit 4).
    bus(0, OBR_STATUS_OFS, 0); chk(rd, 32'h12);
    pulse(1, 0);
    bus(0, OBR_A2B_OFS, 0); chk(rd, 32'h5A);
    sel_ab <= 1; a_val <= 8'h3C;
    settle();
    chk(b_out, 8'h5A);
    $display("a to b test done");
  endtask

  task automatic t_ba();
    dir <= 0; sel_ba <= 0; b_val <= 8'hC3;
    settle();
    chk(a_oe, 1);
    chk(b_oe, 0);
    chk(a_out, 8'hC3);
    pulse(0, 1);
    bus(0, OBR_B2A_OFS, 0); chk(rd, 32'hC3);
    sel_ba <= 1; b_val <= 8'h11;
    settle();
    chk(a_out, 8'hC3);
    $display("b to a test done");
  endtask

  task automatic t_iso();
    oe_n <= 1; a_val <= 8'hAA; b_val <= 8'h55;
    settle();
    chk({a_oe, b_oe}, 0);
    pulse(1, 1);
    bus(0, OBR_A2B_OFS, 0); chk(rd, 32'hAA);
    bus(0, OBR_B2A_OFS, 0); chk(rd, 32'h55);
    a_val <= 8'h01;
    settle();
    bus(0, OBR_A2B_OFS, 0); chk(rd, 32'hAA);
    $display("isolation test done");
  endtask

  // The isolate bit must float both sides even with the enable low.
  task automatic t_ctrl();
    oe_n <= 0; dir <= 1;
    bus(1, OBR_CTRL_OFS, 1);
    settle();
    chk({a_oe, b_oe}, 0);
    bus(0, OBR_CTRL_OFS, 0); chk(rd, 1);
    bus(1, OBR_CTRL_OFS, 0);
    settle();
    chk(b_oe, 1);
    $display("control test done");
  endtask

  // A second reset mid-run must float both sides and clear storage.
  task automatic t_rst_mid();
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    chk({a_oe, b_oe}, 0);
    bus(0, OBR_A2B_OFS, 0); chk(rd, 0);
    bus(0, OBR_B2A_OFS, 0); chk(rd, 0);
    bus(0, OBR_CTRL_OFS, 0); chk(rd, 0);
    settle();
    chk(b_oe, 1);
    $display("mid-run reset test done");
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Main sequence after two cycles of reset.
  initial begin
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    t_reset();
    t_ab();
    t_ba();
    t_iso();
    t_ctrl();
    t_rst_mid();
    tally_and_finish();
  end

  // The tests take about 150 cycles; 3000 means a hang.
  initial begin
    repeat (3000) @(posedge clk_sys);
    fail_count++;
    tally_and_finish();
  end
endmodule

`default_nettype wire
